// File: isc_cfg.svh
// isc_cfg.svh: offsets, field positions and reset values of the status collector
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH
// ****************************************
// register offsets on the host bus
// ****************************************
`define ISC_OFF_STATUS 8'h58
`define ISC_OFF_MASK 8'h5C
`define ISC_OFF_BYTE_TEST 8'h64
// ****************************************
// field positions, status and mask alike
// ****************************************
`define ISC_B_SW 31
`define ISC_B_TXSTOP 25
`define ISC_B_RXSTOP 24
`define ISC_B_DROPHALF 23
`define ISC_B_TXDONE 21
`define ISC_B_RXCOUNT 20
`define ISC_B_TIMER 19
`define ISC_B_PHY 18
`define ISC_B_PME 17
`define ISC_B_TX_STATUS_OVERFLOW_FLAG 16
`define ISC_B_RXBIG 15
`define ISC_B_RXERR 14
`define ISC_B_TXERR 13
`define ISC_B_TDOVR 10
`define ISC_B_TDAVAIL 9
`define ISC_B_TSFULL 8
`define ISC_B_TSLEVEL 7
`define ISC_B_RXDROP 6
`define ISC_B_RSFULL 4
`define ISC_B_RSLEVEL 3
// ****************************************
// reset values and fixed figures
// ****************************************
`define ISC_STS_RST 32'h0000_0000
`define ISC_MASK_RST 32'h0000_0000
`define ISC_IMPL_BITS 32'h83BF_E7DF
`define ISC_BYTE_TEST_VAL 32'h8765_4321
`define ISC_DROP_PRE 32'h7FFF_FFFF
`define ISC_DROP_POST 32'h8000_0000
`define ISC_TIMER_WRAP 16'hFFFF
`define ISC_OVERSIZE_BYTES 16'h0800
`endif

// File: isc_pkg.sv
// isc_pkg.sv: types shared by the status collector modules
`default_nettype none
package isc_pkg;
  // one host bus cycle as seen by the register block
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } isc_host_req_s;
  // conditions from the engines, fifos, timer and pins
  typedef struct packed {
    logic tx_halt_request;
    logic tx_halted;
    logic rx_halted;
    logic [31:0] drop_count;
    logic tx_buf_loaded;
    logic buffer_done_marker;
    logic [11:0] rx_transfer_countdown;
    logic [15:0] timer_count;
    logic phy_event;
    logic power_event;
    logic tx_status_overflow;
    logic rx_frame_done;
    logic [15:0] rx_frame_bytes;
    logic rx_error;
    logic tx_error;
    logic tx_data_write;
    logic tx_data_full;
    logic [7:0] tx_free_blocks;
    logic [7:0] tx_avail_level;
    logic tx_status_full;
    logic [7:0] tx_status_used;
    logic [7:0] tx_status_level;
    logic rx_frame_dropped;
    logic rx_status_full;
    logic [7:0] rx_status_used;
    logic [7:0] rx_status_level;
    logic [2:0] pin_events;
  } isc_events_s;
  // power state of the device
  typedef enum logic {ISC_AWAKE, ISC_ASLEEP} isc_power_e;
  typedef struct packed {
    isc_power_e mode;
  } isc_wake_state_s;
  typedef struct packed {
    logic [1:0] prev;
  } isc_edge_state_s;
  // state of the collector, apart from the halt edge and power state held in its submodules
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] rdata;
    logic [31:0] drop_prev;
    logic [15:0] timer_prev;
    logic [11:0] count_prev;
    logic irq_master;
    logic irq_deliver;
  } isc_state_s;
endpackage : isc_pkg
`default_nettype wire

// File: isc_edge_detect.sv
// isc_edge_detect.sv: rising-edge finder for the halt conditions
`default_nettype none
module isc_edge_detect
  import isc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] level,
  output logic [1:0] rise
);
  isc_edge_state_s st_q; // last sampled levels
  isc_edge_state_s st_d;
  // a halt that lasts must raise its flag once, not every cycle
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bit
      assign rise[gi] = level[gi] & ~st_q.prev[gi];
    end
  endgenerate
  // next state: remember the level
  always_comb begin
    st_d = st_q;
    st_d.prev = level;
  end
  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : isc_edge_detect
`default_nettype wire

// File: isc_power_wake.sv
// isc_power_wake.sv: low-power state, left only by a write to the byte probe
`default_nettype none
module isc_power_wake
  import isc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sleep_request,
  input wire logic probe_write,
  input wire logic power_event,
  output logic low_power
);
  isc_wake_state_s st_q; // current power state
  isc_wake_state_s st_d;
  assign low_power = (st_q.mode == ISC_ASLEEP);
  // next state; a power event is deliberately not a wake source
  always_comb begin
    st_d = st_q;
    case (st_q.mode)
      ISC_AWAKE: begin
        if (sleep_request && !probe_write) begin
          st_d.mode = ISC_ASLEEP;
        end
      end
      ISC_ASLEEP: begin
        if (probe_write) begin
          st_d.mode = ISC_AWAKE;
        end
      end
      default: begin
        st_d.mode = ISC_AWAKE;
      end
    endcase
    if (power_event && !probe_write) begin
      st_d.mode = st_d.mode;
    end
  end
  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{mode: ISC_AWAKE};
    end else begin
      st_q <= st_d;
    end
  end
endmodule : isc_power_wake
`default_nettype wire

// File: isc_status_collector.sv
// isc_status_collector.sv: sticky interrupt status register with mask and master line
// Notes on behaviour
// - writing one clears a flag, zero keeps
// - software flag set while request bit high
// - transmitter halted on request sets bit 25
// - receive engine halt sets bit 24
// - drop counter halfway crossing sets bit 23
// - marked buffer loaded into fifo sets 21
// - receive countdown reaching zero sets bit 20
// - timer wrap zero to FFFF sets 19
// - bit 18 mirrors phy event, read-only
// - power event sets 17, pin independent
// - only byte probe write wakes device
// - power flag ignores deassertion holdoff
// - transmit status fifo overflow sets 16
// - frame over 2048 bytes sets 15
// - receive error sets bit 14
// - transmit error sets bit 13
// - write to full data fifo sets 10
// - free space above level sets 9
// - status fifo full 8, level 7
// - each dropped receive frame sets 6
// - receive status full 4, level 3
// - pin events set bits 2 to 0
// - flags record events regardless of mask
// - master line high on enabled flag
`default_nettype none
`include "isc_cfg.svh"
module isc_status_collector
  import isc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire isc_host_req_s host_req,
  input wire isc_events_s events,
  input wire logic holdoff_active,
  input wire logic sleep_request,
  output logic [31:0] host_rdata,
  output logic irq_master,
  output logic irq_deliver,
  output logic low_power
);
  // ****************************************
  // state and helpers
  // ****************************************
  isc_state_s st_q; // registered state
  isc_state_s st_d; // next state
  logic [1:0] halt_rise; // edges of the two halt conditions
  logic [31:0] set_vec; // hardware set requests this cycle
  logic [31:0] clr_vec; // host clear requests this cycle
  logic wr_hit; // host write strobe
  logic rd_hit; // host read strobe
  logic probe_write; // write of any value to the byte probe

  assign wr_hit = host_req.cs & host_req.wr;
  assign rd_hit = host_req.cs & host_req.rd;
  assign probe_write = wr_hit && (host_req.addr == `ISC_OFF_BYTE_TEST);

  // ****************************************
  // submodules
  // ****************************************
  // halts are levels; only their onset is an event
  isc_edge_detect u_halt_edge (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .level({events.rx_halted, events.tx_halt_request & events.tx_halted}),
    .rise(halt_rise)
  );
  // power state, separate from the flag logic
  isc_power_wake u_wake (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sleep_request(sleep_request),
    .probe_write(probe_write),
    .power_event(events.power_event),
    .low_power(low_power)
  );

  // ****************************************
  // set conditions
  // ****************************************
  // every source writes its bit unconditionally; mask is consulted only as the software request for bit 31
  always_comb begin
    set_vec = '0;
    set_vec[`ISC_B_SW] = st_q.mask[`ISC_B_SW];
    set_vec[`ISC_B_TXSTOP] = halt_rise[0];
    set_vec[`ISC_B_RXSTOP] = halt_rise[1];
    // halfway crossing seen across two samples of the counter
    set_vec[`ISC_B_DROPHALF] = (st_q.drop_prev == `ISC_DROP_PRE)
      && (events.drop_count == `ISC_DROP_POST);
    set_vec[`ISC_B_TXDONE] = events.tx_buf_loaded
      & events.buffer_done_marker;
    // countdown runs to zero as words leave the receive fifo
    set_vec[`ISC_B_RXCOUNT] = (st_q.count_prev != 12'h000)
      && (events.rx_transfer_countdown == 12'h000);
    set_vec[`ISC_B_TIMER] = (st_q.timer_prev == 16'h0000)
      && (events.timer_count == `ISC_TIMER_WRAP);
    set_vec[`ISC_B_PME] = events.power_event;
    set_vec[`ISC_B_TX_STATUS_OVERFLOW_FLAG] = events.tx_status_overflow;
    set_vec[`ISC_B_RXBIG] = events.rx_frame_done
      && (events.rx_frame_bytes > `ISC_OVERSIZE_BYTES);
    set_vec[`ISC_B_RXERR] = events.rx_error;
    set_vec[`ISC_B_TXERR] = events.tx_error;
    set_vec[`ISC_B_TDOVR] = events.tx_data_write
      & events.tx_data_full;
    // level conditions keep setting while they last
    set_vec[`ISC_B_TDAVAIL] = events.tx_free_blocks
      > events.tx_avail_level;
    set_vec[`ISC_B_TSFULL] = events.tx_status_full;
    set_vec[`ISC_B_TSLEVEL] = events.tx_status_used
      > events.tx_status_level;
    set_vec[`ISC_B_RXDROP] = events.rx_frame_dropped;
    set_vec[`ISC_B_RSFULL] = events.rx_status_full;
    set_vec[`ISC_B_RSLEVEL] = events.rx_status_used
      > events.rx_status_level;
    set_vec[2:0] = events.pin_events;
  end

  // ****************************************
  // register file and interrupt lines
  // ****************************************
  always_comb begin
    st_d = st_q;
    clr_vec = '0;
    // acknowledge: ones clear, zeros leave the flag alone
    if (wr_hit && (host_req.addr == `ISC_OFF_STATUS)) begin
      clr_vec = host_req.wdata;
    end
    // set after clear, so an event in the clearing cycle survives
    st_d.status = ((st_q.status & ~clr_vec) | set_vec)
      & `ISC_IMPL_BITS;
    // phy bit follows its source; host writes cannot touch it
    st_d.status[`ISC_B_PHY] = events.phy_event;
    // mask register, reserved bits held at zero
    if (wr_hit && (host_req.addr == `ISC_OFF_MASK)) begin
      st_d.mask = host_req.wdata & `ISC_IMPL_BITS;
    end
    // history of the sampled counters
    st_d.drop_prev = events.drop_count;
    st_d.timer_prev = events.timer_count;
    st_d.count_prev = events.rx_transfer_countdown;
    // read data lands one edge after the read strobe
    if (rd_hit) begin
      if (host_req.addr == `ISC_OFF_STATUS) begin
        st_d.rdata = st_q.status;
      end else if (host_req.addr == `ISC_OFF_MASK) begin
        st_d.rdata = st_q.mask;
      end else if (host_req.addr == `ISC_OFF_BYTE_TEST) begin
        st_d.rdata = `ISC_BYTE_TEST_VAL;
      end else begin
        st_d.rdata = 32'h0000_0000; // unmapped reads as zero
      end
    end
    // internal master line, blind to the holdoff
    st_d.irq_master = |(st_q.status & st_q.mask);
    // during holdoff only the power flag still gets through
    if (holdoff_active) begin
      st_d.irq_deliver = st_q.status[`ISC_B_PME]
        & st_q.mask[`ISC_B_PME];
    end else begin
      st_d.irq_deliver = |(st_q.status & st_q.mask);
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign host_rdata = st_q.rdata;
  assign irq_master = st_q.irq_master;
  assign irq_deliver = st_q.irq_deliver;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic wr_sts; // host write to the status register
  assign wr_sts = wr_hit && (host_req.addr == `ISC_OFF_STATUS);

  clear_on_one_a:
    assert property (wr_sts && host_req.wdata[`ISC_B_RXERR] && !events.rx_error
      |=> !st_q.status[`ISC_B_RXERR])
    else $error("receive error flag not cleared by a written one");

  zero_keeps_a:
    assert property (wr_sts && !host_req.wdata[`ISC_B_TX_STATUS_OVERFLOW_FLAG]
      && st_q.status[`ISC_B_TX_STATUS_OVERFLOW_FLAG] |=> st_q.status[`ISC_B_TX_STATUS_OVERFLOW_FLAG])
    else $error("written zero disturbed a flag");

  sw_flag_set_a:
    assert property (st_q.mask[`ISC_B_SW] |=> st_q.status[`ISC_B_SW])
    else $error("software flag not set by its request bit");

  tx_halt_set_a:
    assert property ($rose(events.tx_halt_request & events.tx_halted)
      |=> st_q.status[`ISC_B_TXSTOP])
    else $error("transmit halt flag missing");

  drop_half_a:
    assert property (events.drop_count == `ISC_DROP_POST
      && $past(events.drop_count) == `ISC_DROP_PRE
      |=> st_q.status[`ISC_B_DROPHALF])
    else $error("dropped counter halfway flag missing");

  timer_wrap_a:
    assert property (events.timer_count == `ISC_TIMER_WRAP
      && $past(events.timer_count) == 16'h0000 |=> st_q.status[`ISC_B_TIMER])
    else $error("timer wrap flag missing");

  phy_mirror_a:
    assert property (##1 st_q.status[`ISC_B_PHY] == $past(events.phy_event))
    else $error("phy bit does not follow its source");

  oversize_a:
    assert property (events.rx_frame_done
      && events.rx_frame_bytes == 16'h0801 |=> st_q.status[`ISC_B_RXBIG])
    else $error("oversize frame flag missing");

  set_wins_a:
    assert property (wr_sts && host_req.wdata[`ISC_B_TXERR] && events.tx_error
      |=> st_q.status[`ISC_B_TXERR])
    else $error("event lost in its clearing cycle");

  master_line_a:
    assert property ((|(st_q.status & st_q.mask)) |=> irq_master)
    else $error("master line low with an enabled flag");

  pme_bypass_a:
    assert property (holdoff_active && st_q.status[`ISC_B_PME]
      && st_q.mask[`ISC_B_PME] |=> irq_deliver)
    else $error("power flag held back by the holdoff");

  wake_probe_a:
    assert property (low_power && !probe_write |=> low_power)
    else $error("device woke without a probe write");

  wake_on_write_a:
    assert property (low_power && probe_write |=> !low_power)
    else $error("probe write did not wake the device");

  rx_halt_set_a:
    assert property ($rose(events.rx_halted) |=> st_q.status[`ISC_B_RXSTOP])
    else $error("receive halt flag missing");

  tx_done_set_a:
    assert property (events.tx_buf_loaded && events.buffer_done_marker
      |=> st_q.status[`ISC_B_TXDONE])
    else $error("marked buffer flag missing");

  pme_set_a:
    assert property (events.power_event |=> st_q.status[`ISC_B_PME])
    else $error("power event flag missing");

  tx_status_overflow_flag_set_a:
    assert property (events.tx_status_overflow |=> st_q.status[`ISC_B_TX_STATUS_OVERFLOW_FLAG])
    else $error("transmit status overflow flag missing");

  rx_err_set_a:
    assert property (events.rx_error |=> st_q.status[`ISC_B_RXERR])
    else $error("receive error flag missing");

  tx_err_set_a:
    assert property (events.tx_error |=> st_q.status[`ISC_B_TXERR])
    else $error("transmit error flag missing");

  overrun_set_a:
    assert property (events.tx_data_write && events.tx_data_full
      |=> st_q.status[`ISC_B_TDOVR])
    else $error("data fifo overrun flag missing");

  space_set_a:
    assert property (events.tx_free_blocks > events.tx_avail_level
      |=> st_q.status[`ISC_B_TDAVAIL])
    else $error("data fifo space flag missing");

  ts_full_set_a:
    assert property (events.tx_status_full |=> st_q.status[`ISC_B_TSFULL])
    else $error("transmit status full flag missing");

  rx_drop_set_a:
    assert property (events.rx_frame_dropped |=> st_q.status[`ISC_B_RXDROP])
    else $error("dropped frame flag missing");

  rs_level_set_a:
    assert property (events.rx_status_used > events.rx_status_level
      |=> st_q.status[`ISC_B_RSLEVEL])
    else $error("receive status level flag missing");

  pin_flags_a:
    assert property (events.pin_events != 3'b000
      |=> (st_q.status[2:0] & $past(events.pin_events)) == $past(events.pin_events))
    else $error("pin event flag missing");

  mask_blind_a:
    assert property (events.tx_status_full && !st_q.mask[`ISC_B_TSFULL]
      |=> st_q.status[`ISC_B_TSFULL])
    else $error("masked source did not set its flag");

  cov_ack_c: cover property (st_q.status[`ISC_B_RXERR] ##1 wr_sts ##1
    !st_q.status[`ISC_B_RXERR]);
  cov_irq_c: cover property ($rose(irq_master));
  cov_wake_c: cover property (low_power ##[1:20] !low_power);
endmodule : isc_status_collector
`default_nettype wire

// File: isc_host_model.sv
// isc_host_model.sv: host processor model on the register bus
`default_nettype none
module isc_host_model
  import isc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [31:0] host_rdata,
  output var isc_host_req_s host_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bus cycles, each entered and left at a falling edge
  // ****
  // idle bus: strobes low, stale fields turned over so nothing leans on them
  task automatic idle();
    host_req.cs = 1'b0;
    host_req.wr = 1'b0;
    host_req.rd = 1'b0;
    host_req.addr = ~host_req.addr;
    host_req.wdata = ~host_req.wdata;
  endtask : idle
  // one write, taken at the rising edge in between
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_req = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    idle();
    @(negedge ref_clk); // a quiet edge, so the next cycle never re-raises cs in this step
  endtask : wr
  // one read, data is settled one edge later
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host_req = '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge ref_clk);
    d = host_rdata;
    idle();
    @(negedge ref_clk); // a quiet edge before the next cycle
  endtask : rd
  // quiet bus from time zero
  initial begin
    host_req = '0;
  end
endmodule : isc_host_model
`default_nettype wire

// File: isc_status_collector_tb_top.sv
// isc_status_collector_tb_top.sv: self-checking bench of the status collector
`default_nettype none
`include "isc_cfg.svh"
module isc_status_collector_tb_top
  import isc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // one table row: two event steps and the status they should leave
  typedef struct packed {
    isc_events_s a;
    isc_events_s b;
    logic [31:0] exp;
  } isc_row_s;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  isc_host_req_s host_req;
  isc_events_s events = '0;
  logic holdoff_active = 1'b0;
  logic sleep_request = 1'b0;
  logic [31:0] host_rdata;
  logic irq_master;
  logic irq_deliver;
  logic low_power;
  int failures = 0;
  int comparisons = 0;
  isc_row_s rows[$];
  isc_events_s ea = '0; // first step of the row being built
  isc_events_s eb = '0; // second step, zero means same as first
  logic [31:0] v;
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  isc_status_collector i_isc_status_collector (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .host_req(host_req),
    .events(events),
    .holdoff_active(holdoff_active),
    .sleep_request(sleep_request),
    .host_rdata(host_rdata),
    .irq_master(irq_master),
    .irq_deliver(irq_deliver),
    .low_power(low_power)
  );
  isc_host_model i_isc_host_model (
    .ref_clk(ref_clk),
    .host_rdata(host_rdata),
    .host_req(host_req)
  );
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read status and compare
  task automatic sts(input logic [31:0] x);
    i_isc_host_model.rd(`ISC_OFF_STATUS, v);
    chk(v, x);
  endtask : sts
  // push a row, then start the next one clean
  task automatic add(input logic [31:0] x);
    rows.push_back('{ea, (eb == '0) ? ea : eb, x});
    ea = '0;
    eb = '0;
  endtask : add
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task automatic give_verdict();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // hang guard: a stuck run is a mismatch
  initial begin
    tick(5000);
    failures++;
    give_verdict();
  end
  // ****
  // main sequence
  // ****
  initial begin
    ea.rx_error = 1'b1;
    add(32'h0000_4000);
    ea.tx_error = 1'b1;
    add(32'h0000_2000);
    ea.tx_status_overflow = 1'b1;
    add(32'h0001_0000);
    ea.rx_frame_dropped = 1'b1;
    add(32'h0000_0040);
    ea.power_event = 1'b1;
    add(32'h0002_0000);
    ea.pin_events = 3'b101;
    add(32'h0000_0005);
    ea.pin_events = 3'b010;
    add(32'h0000_0002);
    ea.tx_buf_loaded = 1'b1;
    ea.buffer_done_marker = 1'b1;
    add(32'h0020_0000);
    ea.rx_frame_done = 1'b1;
    ea.rx_frame_bytes = 16'h0801;
    add(32'h0000_8000);
    ea.rx_frame_done = 1'b1;
    ea.rx_frame_bytes = 16'h0800;
    add(32'h0000_0000);
    ea.tx_data_write = 1'b1;
    ea.tx_data_full = 1'b1;
    add(32'h0000_0400);
    ea.tx_free_blocks = 8'h05;
    ea.tx_avail_level = 8'h04;
    add(32'h0000_0200);
    ea.tx_status_full = 1'b1;
    add(32'h0000_0100);
    ea.tx_status_used = 8'h03;
    ea.tx_status_level = 8'h02;
    add(32'h0000_0080);
    ea.rx_status_full = 1'b1;
    add(32'h0000_0010);
    ea.rx_status_used = 8'h03;
    ea.rx_status_level = 8'h02;
    add(32'h0000_0008);
    ea.rx_halted = 1'b1;
    add(32'h0100_0000);
    ea.tx_halt_request = 1'b1;
    ea.tx_halted = 1'b1;
    add(32'h0200_0000);
    ea.tx_halted = 1'b1;
    add(32'h0000_0000);
    ea.drop_count = `ISC_DROP_PRE;
    eb.drop_count = `ISC_DROP_POST;
    add(32'h0080_0000);
    ea.drop_count = 32'h7FFF_FFFE;
    eb.drop_count = `ISC_DROP_PRE;
    add(32'h0000_0000);
    eb.timer_count = `ISC_TIMER_WRAP;
    add(32'h0008_0000);
    ea.rx_transfer_countdown = 12'h005;
    add(32'h0010_0000);
    tick(6);
    arst_n = 1'b1;
    tick(1);
    // table rows with the mask left at zero
    foreach (rows[i]) begin
      events = rows[i].a;
      tick(1);
      events = rows[i].b;
      tick(1);
      events = '0;
      tick(3);
      sts(rows[i].exp);
      chk({31'h0, irq_master}, 32'h0);
      i_isc_host_model.wr(`ISC_OFF_STATUS, 32'hFFFF_FFFF);
      sts(32'h0);
    end
    // full mask: reserved bits read zero, software request sets bit 31
    i_isc_host_model.wr(`ISC_OFF_MASK, 32'hFFFF_FFFF);
    i_isc_host_model.rd(`ISC_OFF_MASK, v);
    chk(v, `ISC_IMPL_BITS);
    sts(32'h8000_0000);
    chk({31'h0, irq_master}, 32'h1);
    // holdoff blocks delivery except for the power flag
    holdoff_active = 1'b1;
    tick(2);
    chk({31'h0, irq_deliver}, 32'h0);
    events.power_event = 1'b1;
    tick(1);
    events = '0;
    tick(2);
    chk({31'h0, irq_deliver}, 32'h1);
    holdoff_active = 1'b0;
    // request still high re-sets the flag, dropping it lets the clear stick
    i_isc_host_model.wr(`ISC_OFF_STATUS, 32'h8000_0000);
    sts(32'h8002_0000);
    i_isc_host_model.wr(`ISC_OFF_MASK, 32'h0);
    i_isc_host_model.wr(`ISC_OFF_STATUS, 32'hFFFF_FFFF);
    sts(32'h0);
    // event only in the clearing cycle must survive, writing zero keeps
    events.rx_error = 1'b1;
    fork
      i_isc_host_model.wr(`ISC_OFF_STATUS, 32'h0000_4000);
      begin
        tick(1);
        events = '0;
      end
    join
    sts(32'h0000_4000);
    i_isc_host_model.wr(`ISC_OFF_STATUS, 32'h0);
    sts(32'h0000_4000);
    i_isc_host_model.wr(`ISC_OFF_STATUS, 32'hFFFF_FFFF);
    // phy bit follows its source and ignores writes
    events.phy_event = 1'b1;
    tick(2);
    i_isc_host_model.wr(`ISC_OFF_STATUS, 32'h0004_0000);
    sts(32'h0004_0000);
    events = '0;
    tick(2);
    sts(32'h0);
    // only a probe write wakes the device
    sleep_request = 1'b1;
    tick(1);
    sleep_request = 1'b0;
    chk({31'h0, low_power}, 32'h1);
    events.power_event = 1'b1;
    tick(1);
    events = '0;
    i_isc_host_model.wr(`ISC_OFF_STATUS, 32'hFFFF_FFFF);
    tick(1);
    chk({31'h0, low_power}, 32'h1);
    i_isc_host_model.wr(`ISC_OFF_BYTE_TEST, 32'h0);
    chk({31'h0, low_power}, 32'h0);
    // unmapped place reads zero and keeps nothing
    i_isc_host_model.wr(8'h60, 32'hFFFF_FFFF);
    i_isc_host_model.rd(8'h60, v);
    chk(v, 32'h0);
    // second reset in mid-run clears flags, mask and outputs
    i_isc_host_model.wr(`ISC_OFF_MASK, 32'h0000_4000);
    events.rx_error = 1'b1;
    tick(1);
    events = '0;
    arst_n = 1'b0;
    tick(2);
    chk({29'h0, irq_master, irq_deliver, low_power}, 32'h0);
    arst_n = 1'b1;
    tick(1);
    sts(`ISC_STS_RST);
    i_isc_host_model.rd(`ISC_OFF_MASK, v);
    chk(v, `ISC_MASK_RST);
    give_verdict();
  end
endmodule : isc_status_collector_tb_top
`default_nettype wire
